// ==== logic/phase_balance.sv ====
// per-phase on-time trim from current imbalance against the mean
// assumes current samples arrive synchronised on clk_sys
module phase_balance
	import rail_ctrl_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [2:0]  phase_active,
	input  wire logic [29:0] phase_cur,
	output logic [2:0]       trim_shorter,
	output logic [2:0]       trim_longer
);
	import rail_ctrl_pkg::*;

	logic [11:0] sum;
	logic [11:0] avg;
	logic [1:0]  cnt;

	// average over active phases only
	always_comb begin
		sum = 12'h000;
		cnt = 2'h0;
		for (int i = 0; i < NUM_PHASES; i++) begin
			if (phase_active[i]) begin
				sum = sum + 12'(phase_cur[i*10 +: 10]);
				cnt = cnt + 2'h1;
			end
		end
		avg = (cnt == 2'h0) ? 12'h000 : sum / 12'(cnt);
	end

	// shorten phases above average, lengthen those below
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			trim_shorter <= 3'h0;
			trim_longer  <= 3'h0;
		end else begin
			for (int i = 0; i < NUM_PHASES; i++) begin
				trim_shorter[i] <= phase_active[i]
					&& (12'(phase_cur[i*10 +: 10]) > avg);
				trim_longer[i]  <= phase_active[i]
					&& (12'(phase_cur[i*10 +: 10]) < avg);
			end
		end
	end

	property p_no_both;
		@(posedge clk_sys) disable iff (!rstn)
		!(|(trim_shorter & trim_longer));
	endproperty
	a_no_both: assert property (p_no_both)
		else $error("phase trimmed both ways");
endmodule // phase_balance

// ==== logic/rail_ctrl.sv ====
// core rail power-state control, phase gating, boost current, thermal code
// assumes command strobes come from the serial link decoder on clk_sys
// and the sampled pin values come from converters outside this clock
//
// Overview of operation
// - After reset the rail runs in the full-phase state with all phases.
// - A power-state command changes the state at once.
// - In single-phase ccm only phase 1 switches; phases 2 and 3 float.
// - In emulation state phase 1 runs diode emulation; 2 and 3 float.
// - A voltage command forces the full-phase state with all phases.
// - After the target is reached the old request stays discarded.
// - The offset enable is latched on the third clock after reset release if pin above 0.6V.
// - Upward moves source 8uA when fast and 2uA when slow.
// - Downward moves source no boost current.
// - The emulation state selects the alternative ramp setting.
// - Phases above the mean are shortened, below are lengthened.
// - The sense voltage is coded from 1.46V to 1.845V in 55mV steps.
// - Each code bit is set while the voltage is at or above its threshold.
// - Bit 6 asserts alert and status bit 1 until bit 5 clears.
// - Bit 7 drives the hot line low until bit 6 clears.
// - Status bit 1 follows the alert directly and is not latched.
module rail_ctrl
	import rail_ctrl_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	input  wire logic                    power_state_command,
	input  wire logic [1:0]              ps_code,
	input  wire rail_ctrl_pkg::volt_cmd_t voltage_target_command,
	input  wire logic                    target_reached,
	input  wire logic [11:0]             offset_pin_mv,
	input  wire logic [11:0]             thermal_sense_pin_mv,
	input  wire logic [2:0]              pwm_req,
	input  wire logic [29:0]             phase_cur,
	output rail_ctrl_pkg::power_state_t  power_state,
	output rail_ctrl_pkg::phase_drv_t [2:0] phase_drv,
	output logic                         diode_emulation,
	output logic                         alt_ramp,
	output logic                         offset_enable,
	output logic [3:0]                   transition_boost_pin_ua,
	output logic [7:0]                   thermal_band_code,
	output logic [7:0]                   status_one,
	output logic                         alert_o,
	output logic                         alert_oe,
	output logic                         hot_indicator_o,
	output logic                         hot_indicator_oe,
	output logic [2:0]                   trim_shorter,
	output logic [2:0]                   trim_longer
);
	import rail_ctrl_pkg::*;

	power_state_t state_ff;
	power_state_t nxt_state;
	logic [11:0]  ofs_s1_ff;
	logic [11:0]  ofs_s2_ff;
	logic [11:0]  thermal_sense_pin_s1_ff;
	logic [11:0]  thermal_sense_pin_s2_ff;
	logic [2:0]   rst_age_ff;
	logic         ofs_en_ff;
	logic         in_trans_ff;
	logic         trans_up_ff;
	logic         trans_fast_ff;
	logic [3:0]   boost_ff;
	logic [2:0]   pwm_ff;
	logic [2:0]   active;
	logic         alert_low;
	logic         hot_low;

	// map a command code to a state; unknown codes mean full phase
	function automatic power_state_t decode_ps(input logic [1:0] code);
		case (code)
			PS_CODE_CCM:  decode_ps = single_phase_ccm_state;
			PS_CODE_EMUL: decode_ps = single_phase_emulation_state;
			default:      decode_ps = full_phase_state;
		endcase
	endfunction

	// two-stage synchronisers for converter samples from the pins
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ofs_s1_ff  <= 12'h000;
			ofs_s2_ff  <= 12'h000;
			thermal_sense_pin_s1_ff <= 12'h000;
			thermal_sense_pin_s2_ff <= 12'h000;
		end else begin
			ofs_s1_ff  <= offset_pin_mv;
			ofs_s2_ff  <= ofs_s1_ff;
			thermal_sense_pin_s1_ff <= thermal_sense_pin_mv;
			thermal_sense_pin_s2_ff <= thermal_sense_pin_s1_ff;
		end
	end

	// next state: voltage command has priority over power-state command
	always_comb begin
		nxt_state = state_ff;
		if (voltage_target_command.valid) begin
			nxt_state = full_phase_state;
		end else if (power_state_command) begin
			nxt_state = decode_ps(ps_code);
		end
	end

	// state register, only commands move it
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_ff <= full_phase_state;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// count cycles after reset release so the strap sees settled samples
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rst_age_ff <= 3'h0;
		end else if (rst_age_ff != 3'h3) begin
			rst_age_ff <= rst_age_ff + 3'h1;
		end
	end

	// offset enable latched once, after the synchroniser fills
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ofs_en_ff <= 1'b0;
		end else if (rst_age_ff == 3'h2) begin
			ofs_en_ff <= (ofs_s2_ff > OFFSET_EN_MV);
		end
	end

	// track a voltage transition until the target is reached
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			in_trans_ff   <= 1'b0;
			trans_up_ff   <= 1'b0;
			trans_fast_ff <= 1'b0;
		end else if (voltage_target_command.valid) begin
			in_trans_ff   <= 1'b1;
			trans_up_ff   <= voltage_target_command.up;
			trans_fast_ff <= voltage_target_command.fast;
		end else if (target_reached) begin
			in_trans_ff   <= 1'b0;
		end
	end

	// boost current only while rising
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			boost_ff <= BOOST_NONE_UA;
		end else if (in_trans_ff && trans_up_ff) begin
			boost_ff <= trans_fast_ff ? BOOST_FAST_UA : BOOST_SLOW_UA;
		end else begin
			boost_ff <= BOOST_NONE_UA;
		end
	end

	// phase enables by state
	always_comb begin
		case (state_ff)
			full_phase_state: active = 3'h7;
			single_phase_ccm_state: active = 3'h1;
			single_phase_emulation_state: active = 3'h1;
			default: active = 3'h7;
		endcase
	end

	// registered pulse levels, floated phases held low
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pwm_ff <= 3'h0;
		end else begin
			pwm_ff <= pwm_req & active;
		end
	end

	// drive structures: enable low is high impedance
	always_comb begin
		for (int i = 0; i < NUM_PHASES; i++) begin
			phase_drv[i].pulse = pwm_ff[i];
			phase_drv[i].en    = active[i];
		end
	end

	// mode outputs
	assign power_state     = state_ff;
	assign diode_emulation = (state_ff == single_phase_emulation_state);
	assign alt_ramp        = (state_ff == single_phase_emulation_state);
	assign offset_enable   = ofs_en_ff;
	assign transition_boost_pin_ua = boost_ff;

	thermal_code u_thermal (
		.clk_sys           (clk_sys),
		.rstn              (rstn),
		.therm_mv          (thermal_sense_pin_s2_ff),
		.thermal_band_code (thermal_band_code),
		.alert_low         (alert_low),
		.hot_low           (hot_low)
	);

	phase_balance u_balance (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.phase_active (active),
		.phase_cur    (phase_cur),
		.trim_shorter (trim_shorter),
		.trim_longer  (trim_longer)
	);

	// status bit 1 follows the alert level, no latch
	always_comb begin
		status_one = 8'h00;
		status_one[STATUS_THERM_BIT] = ~alert_low;
	end

	// open-drain lines: drive low when asserted, otherwise release
	assign alert_o          = 1'b0;
	assign alert_oe         = ~alert_low;
	assign hot_indicator_o  = 1'b0;
	assign hot_indicator_oe = ~hot_low;

	// checks
	sequence s_volt;
		voltage_target_command.valid;
	endsequence

	property p_volt_full;
		@(posedge clk_sys) disable iff (!rstn)
		s_volt |=> state_ff == full_phase_state;
	endproperty
	a_volt_full: assert property (p_volt_full)
		else $error("voltage command did not force full phase");

	property p_ps_now;
		@(posedge clk_sys) disable iff (!rstn)
		power_state_command && !voltage_target_command.valid
			|=> state_ff == decode_ps($past(ps_code));
	endproperty
	a_ps_now: assert property (p_ps_now)
		else $error("power-state command not taken at once");

	property p_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!power_state_command && !voltage_target_command.valid
			|=> $stable(state_ff);
	endproperty
	a_hold: assert property (p_hold)
		else $error("state moved without a command");

	property p_float;
		@(posedge clk_sys) disable iff (!rstn)
		state_ff != full_phase_state |-> !phase_drv[1].en && !phase_drv[2].en;
	endproperty
	a_float: assert property (p_float)
		else $error("phases 2 or 3 driven in reduced state");

	// first cycle out of reset: full phase with every phase enabled
	property p_full;
		@(posedge clk_sys) disable iff (!rstn)
		!$past(rstn) |-> state_ff == full_phase_state
			&& {phase_drv[2].en, phase_drv[1].en, phase_drv[0].en} == 3'h7;
	endproperty
	a_full: assert property (p_full)
		else $error("rail not in full phase after reset");

	property p_ramp;
		@(posedge clk_sys) disable iff (!rstn)
		power_state_command && ps_code == PS_CODE_EMUL
			&& !voltage_target_command.valid |=> alt_ramp && diode_emulation;
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp not switched in emulation state");

	property p_boost_fast;
		@(posedge clk_sys) disable iff (!rstn)
		voltage_target_command.valid && voltage_target_command.up
			&& voltage_target_command.fast ##1 !target_reached
			|=> boost_ff == BOOST_FAST_UA;
	endproperty
	a_boost_fast: assert property (p_boost_fast)
		else $error("fast boost current wrong");

	property p_no_down;
		@(posedge clk_sys) disable iff (!rstn)
		!trans_up_ff |=> boost_ff == BOOST_NONE_UA;
	endproperty
	a_no_down: assert property (p_no_down)
		else $error("boost sourced while falling");

	// status flag drops with the alert, it is never held on its own
	property p_status;
		@(posedge clk_sys) disable iff (!rstn)
		!thermal_band_code[ALERT_CLR_BIT] |=> !status_one[STATUS_THERM_BIT];
	endproperty
	a_status: assert property (p_status)
		else $error("status bit held after alert release");

	property p_strap;
		@(posedge clk_sys) disable iff (!rstn)
		rst_age_ff == 3'h2 |=> ofs_en_ff == ($past(ofs_s2_ff) > OFFSET_EN_MV);
	endproperty
	a_strap: assert property (p_strap)
		else $error("offset enable not latched");
endmodule // rail_ctrl

// ==== logic/rail_ctrl_pkg.sv ====
// shared constants and types for the core rail state and thermal slice
// assumes one clock domain (clk_sys, 100 MHz) and synchronous low reset
package rail_ctrl_pkg;
	// power states
	typedef enum logic [1:0] {
		full_phase_state,
		single_phase_ccm_state,
		single_phase_emulation_state
	} power_state_t;

	// power-state command encoding carried with the command strobe
	localparam logic [1:0] PS_CODE_FULL = 2'h0;
	localparam logic [1:0] PS_CODE_CCM  = 2'h1;
	localparam logic [1:0] PS_CODE_EMUL = 2'h2;

	// thermometer code: thresholds in millivolts, bit 0 lowest
	localparam int THERM_BITS     = 8;
	localparam int THERM_BASE_MV  = 1460;
	localparam int THERM_TOP_MV   = 1845;
	localparam int THERM_STEP_MV  = 55;
	localparam int ALERT_SET_BIT  = 6;
	localparam int ALERT_CLR_BIT  = 5;
	localparam int HOT_SET_BIT    = 7;
	localparam int HOT_CLR_BIT    = 6;
	// offset pin enable threshold in millivolts
	localparam logic [11:0] OFFSET_EN_MV = 12'h258;
	// boost current codes in microamps
	localparam logic [3:0] BOOST_FAST_UA = 4'h8;
	localparam logic [3:0] BOOST_SLOW_UA = 4'h2;
	localparam logic [3:0] BOOST_NONE_UA = 4'h0;
	// on-time trim limits per phase
	localparam logic [3:0] TRIM_ZERO = 4'h0;
	localparam int NUM_PHASES = 3;
	// status register thermal flag position
	localparam int STATUS_THERM_BIT = 1;

	// voltage command from the serial link
	typedef struct packed {
		logic       valid;
		logic       fast;   // 1 fast slew, 0 slow slew
		logic       up;     // target above present output
	} volt_cmd_t;

	// per-phase drive: pulse level and enable (0 means high impedance)
	typedef struct packed {
		logic pulse;
		logic en;
	} phase_drv_t;
endpackage

// ==== logic/thermal_code.sv ====
// thermometer encoder for the sensed temperature voltage with alert/hot
// assumes therm_mv is already synchronised sample data on clk_sys
module thermal_code
	import rail_ctrl_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [11:0] therm_mv,
	output logic [7:0]       thermal_band_code,
	output logic             alert_low,
	output logic             hot_low
);
	import rail_ctrl_pkg::*;

	logic [7:0] nxt_code;
	logic       alert_ff;
	logic       hot_ff;

	// threshold of each bit, base plus step per position
	function automatic logic [11:0] thr(input int idx);
		thr = 12'(THERM_BASE_MV + idx * THERM_STEP_MV);
	endfunction

	// compare against each threshold
	always_comb begin
		for (int i = 0; i < THERM_BITS; i++) begin
			nxt_code[i] = (therm_mv >= thr(i));
		end
	end

	// code register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			thermal_band_code <= 8'h00;
		end else begin
			thermal_band_code <= nxt_code;
		end
	end

	// alert hysteresis: set on bit 6, release on bit 5 clear
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			alert_ff <= 1'b0;
		end else if (thermal_band_code[ALERT_SET_BIT]) begin
			alert_ff <= 1'b1;
		end else if (!thermal_band_code[ALERT_CLR_BIT]) begin
			alert_ff <= 1'b0;
		end
	end

	// hot indicator: set on bit 7, release on bit 6 clear
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			hot_ff <= 1'b0;
		end else if (thermal_band_code[HOT_SET_BIT]) begin
			hot_ff <= 1'b1;
		end else if (!thermal_band_code[HOT_CLR_BIT]) begin
			hot_ff <= 1'b0;
		end
	end

	assign alert_low = ~alert_ff;
	assign hot_low   = ~hot_ff;

	// alert must track bit 6 set a cycle later
	property p_alert_set;
		@(posedge clk_sys) disable iff (!rstn)
		thermal_band_code[ALERT_SET_BIT] |=> !alert_low;
	endproperty
	a_alert_set: assert property (p_alert_set)
		else $error("alert not asserted after bit 6");

	property p_hot_release;
		@(posedge clk_sys) disable iff (!rstn)
		!thermal_band_code[HOT_CLR_BIT] && !thermal_band_code[HOT_SET_BIT]
			|=> hot_low;
	endproperty
	a_hot_release: assert property (p_hot_release)
		else $error("hot not released after bit 6 clear");

	property p_code_track;
		@(posedge clk_sys) disable iff (!rstn)
		(therm_mv >= 12'(THERM_TOP_MV)) |=> thermal_band_code[HOT_SET_BIT];
	endproperty
	a_code_track: assert property (p_code_track)
		else $error("top code bit missing");
endmodule // thermal_code

// ==== verification/host_link_model.sv ====
// host side of the serial voltage-id link: issues state and voltage moves
// assumes clk_sys from the bench; every change lands 1 ns after the edge
module host_link_model
	import rail_ctrl_pkg::*;
(
	input  wire logic                      clk_sys,
	output logic                           power_state_command,
	output logic [1:0]                     ps_code,
	output rail_ctrl_pkg::volt_cmd_t       voltage_target_command,
	output logic                           target_reached
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle link: qualifiers never keep their last value
	initial begin
		power_state_command    = 1'b0;
		ps_code                = 2'h3;
		voltage_target_command = '0;
		target_reached         = 1'b0;
	end

	// one-cycle state request; needed again after any voltage move
	task automatic send_ps(input logic [1:0] code);
		@(posedge clk_sys);
		#1;
		power_state_command = 1'b1;
		ps_code = code;
		@(posedge clk_sys);
		#1;
		power_state_command = 1'b0;
		ps_code = ~code;
	endtask

	// one-cycle voltage move with slew and direction
	task automatic send_vid(input logic fast, input logic up);
		@(posedge clk_sys);
		#1;
		voltage_target_command = '{valid: 1'b1, fast: fast, up: up};
		@(posedge clk_sys);
		#1;
		voltage_target_command = '{valid: 1'b0, fast: ~fast, up: ~up};
	endtask

	// output arrived at the target
	task automatic reach();
		@(posedge clk_sys);
		#1;
		target_reached = 1'b1;
		@(posedge clk_sys);
		#1;
		target_reached = 1'b0;
	endtask
endmodule // host_link_model

// ==== verification/rail_ctrl_tb.sv ====
// self-checking bench for the core rail state and thermal slice
// assumes the host model drives the link; bench drives the pin samples
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	failures++; $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module rail_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rail_ctrl_pkg::*;

	logic             clk_sys, rstn, power_state_command, target_reached;
	logic [1:0]       ps_code;
	volt_cmd_t        voltage_target_command;
	logic [11:0]      offset_pin_mv, thermal_sense_pin;
	logic [2:0]       pwm_req, trim_shorter, trim_longer;
	logic [29:0]      phase_cur;
	power_state_t     power_state;
	phase_drv_t [2:0] phase_drv;
	logic             diode_emulation, alt_ramp, offset_enable;
	logic [3:0]       boost;
	logic [7:0]       thermal_band_code, status_one;
	logic             alert_o, alert_oe, hot_o, hot_oe, al, ht;
	int               failures, samples_checked;

	rail_ctrl u_dut (.clk_sys(clk_sys), .rstn(rstn),
		.power_state_command(power_state_command), .ps_code(ps_code),
		.voltage_target_command(voltage_target_command),
		.target_reached(target_reached), .offset_pin_mv(offset_pin_mv),
		.thermal_sense_pin_mv(thermal_sense_pin), .pwm_req(pwm_req),
		.phase_cur(phase_cur), .power_state(power_state),
		.phase_drv(phase_drv), .diode_emulation(diode_emulation),
		.alt_ramp(alt_ramp), .offset_enable(offset_enable),
		.transition_boost_pin_ua(boost),
		.thermal_band_code(thermal_band_code), .status_one(status_one),
		.alert_o(alert_o), .alert_oe(alert_oe), .hot_indicator_o(hot_o),
		.hot_indicator_oe(hot_oe), .trim_shorter(trim_shorter),
		.trim_longer(trim_longer));

	host_link_model u_host (.clk_sys(clk_sys),
		.power_state_command(power_state_command), .ps_code(ps_code),
		.voltage_target_command(voltage_target_command),
		.target_reached(target_reached));

	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// reset with a given offset pin level, held steady across release
	task automatic do_reset(input logic [11:0] ofs);
		@(posedge clk_sys);
		#1;
		rstn = 1'b0;
		offset_pin_mv = ofs;
		repeat (6) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		`CHK("state", full_phase_state, power_state)
		`CHK("en", 3'h7, {phase_drv[2].en, phase_drv[1].en,
			phase_drv[0].en})
		`CHK("ofs_en", (ofs > OFFSET_EN_MV), offset_enable)
	endtask

	// walk through every state code, reduced states back to back
	task automatic t_states();
		logic [1:0]   seq [6];
		logic         red;
		power_state_t st;
		seq = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h2, 2'h0};
		for (int i = 0; i < 6; i++) begin
			u_host.send_ps(seq[i]);
			red = (seq[i] == PS_CODE_CCM) || (seq[i] == PS_CODE_EMUL);
			st = (seq[i] == PS_CODE_CCM) ? single_phase_ccm_state :
				(seq[i] == PS_CODE_EMUL) ? single_phase_emulation_state :
				full_phase_state;
			`CHK("state", st, power_state)
			`CHK("en", {~red, ~red, 1'b1}, {phase_drv[2].en,
				phase_drv[1].en, phase_drv[0].en})
			`CHK("pulse1", 1'b1, phase_drv[0].pulse)
			`CHK("dem", (seq[i] == PS_CODE_EMUL), diode_emulation)
			`CHK("ramp", (seq[i] == PS_CODE_EMUL), alt_ramp)
		end
	endtask

	// voltage moves out of the emulation state, all slew and directions
	task automatic t_vid();
		logic [3:0] exp_ua;
		for (int i = 0; i < 4; i++) begin
			u_host.send_ps(PS_CODE_EMUL);
			u_host.send_vid(i[0], i[1]);
			`CHK("state", full_phase_state, power_state)
			`CHK("en", 3'h7, {phase_drv[2].en, phase_drv[1].en,
				phase_drv[0].en})
			exp_ua = !i[1] ? BOOST_NONE_UA : i[0] ? BOOST_FAST_UA :
				BOOST_SLOW_UA;
			@(posedge clk_sys);
			#1;
			`CHK("boost", exp_ua, boost)
			`CHK("pulse", 3'h7, {phase_drv[2].pulse, phase_drv[1].pulse,
				phase_drv[0].pulse})
			u_host.reach();
			@(posedge clk_sys);
			#1;
			`CHK("boost_end", BOOST_NONE_UA, boost)
			repeat (3) @(posedge clk_sys);
			#1;
			`CHK("state", full_phase_state, power_state)
		end
	endtask

	// one phase above the mean, one below, one on it
	task automatic t_balance();
		@(posedge clk_sys);
		#1;
		phase_cur = {10'h0C8, 10'h064, 10'h12C};
		repeat (6) @(posedge clk_sys);
		#1;
		`CHK("shorter", 3'b001, trim_shorter)
		`CHK("longer", 3'b010, trim_longer)
	endtask

	// one sense level; code and hysteresis worked out here
	task automatic t_therm(input int mv);
		logic [7:0] code;
		for (int i = 0; i < THERM_BITS; i++)
			code[i] = (mv >= THERM_BASE_MV + THERM_STEP_MV * i);
		if (code[ALERT_SET_BIT]) al = 1'b1;
		else if (!code[ALERT_CLR_BIT]) al = 1'b0;
		if (code[HOT_SET_BIT]) ht = 1'b1;
		else if (!code[HOT_CLR_BIT]) ht = 1'b0;
		@(posedge clk_sys);
		#1;
		thermal_sense_pin = 12'(mv);
		repeat (5) @(posedge clk_sys);
		#1;
		`CHK("code", code, thermal_band_code)
		`CHK("alert", {al, 1'b0}, {alert_oe, alert_o})
		`CHK("status", {6'h0, al, 1'b0}, status_one)
		`CHK("hot", {ht, 1'b0}, {hot_oe, hot_o})
	endtask

	// end of run: counts, then verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		#500000;
		failures++;
		finish_test();
	end

	// main sequence
	initial begin
		int lv [10];
		failures = 0;
		samples_checked = 0;
		al = 1'b0;
		ht = 1'b0;
		rstn = 1'b0;
		offset_pin_mv = 12'h2BC;
		thermal_sense_pin = 12'h3E8;
		pwm_req = 3'h7;
		phase_cur = {10'h0C8, 10'h0C8, 10'h0C8};
		lv = '{1400, 1515, 1790, 1740, 1700, 1845, 1800, 1780, 1734, 1460};
		do_reset(12'h2BC);
		t_states();
		t_vid();
		t_balance();
		foreach (lv[i]) t_therm(lv[i]);
		do_reset(12'h258);
		do_reset(12'h000);
		finish_test();
	end
endmodule // rail_ctrl_tb
